// >>> src/tick_pkg.sv
// constants, tap tables and carrier types for the periodic tick unit
// assumes the shared divider chain is built elsewhere and arrives as taps
package tick_pkg;

    // ==========================================================
    // chain widths: fast bit k toggles at fast_clock/2^(k+1)
    localparam int FAST_W = 23;
    localparam int SLOW_W = 15;

    // ==========================================================
    // register map, word addresses on the avalon slave
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] STATUS_ADDR = 2'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hEF;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // status register bit positions
    localparam int STAT_TICK_TAP = 0;
    localparam int STAT_BUZ_TAP = 1;
    localparam int STAT_PRESC = 2;
    localparam int STAT_SLOW = 3;

    // ==========================================================
    // tap tables, chain bit index per select code
    localparam logic [4:0] FAST_TICK_IDX [0:7] = '{5'h16, 5'h14, 5'h0F,
        5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h08};
    localparam logic [3:0] SLOW_TICK_IDX [0:7] = '{4'hE, 4'hC, 4'h7,
        4'h5, 4'h4, 4'h3, 4'h2, 4'h0};
    localparam logic [4:0] FAST_BUZ_IDX [0:3] = '{5'h0C, 5'h0B, 5'h0A,
        5'h09};
    localparam logic [3:0] SLOW_BUZ_IDX [0:3] = '{4'h4, 4'h3, 4'h2, 4'h1};

    // ==========================================================
    // carriers and state
    typedef struct packed {
        logic slow_mode;
        logic prescaler_source_select;
    } clock_mode_t;

    typedef struct packed {
        logic buzzer_out_enable;
        logic [1:0] buzzer_freq_select;
        logic spare;
        logic tick_enable;
        logic [2:0] tick_period_select;
    } tick_ctrl_t;

    typedef struct packed {
        tick_ctrl_t ctrl;
        logic waitreq;
        logic [31:0] rdata;
        logic prev_tap;
        logic armed;
        logic tick_irq;
        logic tick_take;
        logic buzzer_n;
    } tick_state_t;

endpackage : tick_pkg

// >>> src/tick_tap_select.sv
// tap selector: picks the tick and buzzer taps off the divider chain
// assumes chain bits are synchronous to the clock of the caller
`timescale 1ns/1ps
module tick_tap_select
    import tick_pkg::*;
(
    // divider chain taps
    input wire logic [FAST_W-1:0] fast_chain,
    input wire logic [SLOW_W-1:0] slow_chain,
    // selection
    input wire clock_mode_t clock_mode,
    input wire tick_ctrl_t ctrl,
    // chosen taps
    output logic tick_tap,
    output logic buz_tap
);

    logic use_slow;

    // ==========================================================
    // slow column whenever the prescaler picks slow_clock or in slow mode;
    // in slow mode codes above 001 are not legal, the slow column is kept
    assign use_slow = clock_mode.slow_mode
        | clock_mode.prescaler_source_select;

    // both columns index the same code, the tap table and the chain differ
    always_comb begin
        if (use_slow) begin
            tick_tap = slow_chain[SLOW_TICK_IDX[ctrl.tick_period_select]];
            buz_tap = slow_chain[SLOW_BUZ_IDX[ctrl.buzzer_freq_select]];
        end else begin
            tick_tap = fast_chain[FAST_TICK_IDX[ctrl.tick_period_select]];
            buz_tap = fast_chain[FAST_BUZ_IDX[ctrl.buzzer_freq_select]];
        end
    end

endmodule : tick_tap_select

// >>> src/periodic_tick_unit.sv
// periodic tick unit: time-base interrupt and buzzer square wave
// assumes the divider chain runs free outside and avalon-mm master
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module periodic_tick_unit
    import tick_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // divider chain and operating mode
    input wire logic [FAST_W-1:0] fast_chain,
    input wire logic [SLOW_W-1:0] slow_chain,
    input wire clock_mode_t clock_mode,
    // interrupt controller side
    input wire logic tick_irq_enable,
    input wire logic irq_master_flag,
    output logic tick_irq,
    output logic tick_irq_take,
    // buzzer pin, active low
    output logic buzzer_out_pin_n
);

    // ==========================================================
    // state and taps
    tick_state_t st_reg;
    tick_state_t st_next;
    logic tick_tap;
    logic buz_tap;
    logic req;
    logic fall;
    logic [31:0] status_word;

    tick_tap_select taps (
        .fast_chain(fast_chain),
        .slow_chain(slow_chain),
        .clock_mode(clock_mode),
        .ctrl(st_reg.ctrl),
        .tick_tap(tick_tap),
        .buz_tap(buz_tap)
    );

    // ==========================================================
    // helper terms
    assign req = avs_read | avs_write;
    // armed stays low the first cycle after enable, so a tap switched by the
    // same write cannot fake an edge against the old tap
    assign fall = st_reg.ctrl.tick_enable & st_reg.armed & st_reg.prev_tap
        & ~tick_tap;

    // status snapshot, upper bits read as zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_TICK_TAP] = tick_tap;
        status_word[STAT_BUZ_TAP] = buz_tap;
        status_word[STAT_PRESC] = clock_mode.prescaler_source_select;
        status_word[STAT_SLOW] = clock_mode.slow_mode;
    end

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        // waitrequest drops for exactly one cycle per request
        st_next.waitreq = ~(req & st_reg.waitreq);
        if (req & st_reg.waitreq) begin
            if (avs_address == CTRL_ADDR) begin
                st_next.rdata = {24'h00_0000, st_reg.ctrl};
            end else if (avs_address == STATUS_ADDR) begin
                st_next.rdata = status_word;
            end else begin
                st_next.rdata = UNMAPPED_READ;
            end
        end
        // writes land only at the edge that sees waitrequest low
        if (avs_write & ~st_reg.waitreq & (avs_address == CTRL_ADDR)
            & avs_byteenable[0]) begin
            st_next.ctrl = avs_writedata[7:0] & CTRL_WRITE_MASK;
        end
        // the chain is only watched, never cleared by enabling
        st_next.prev_tap = tick_tap;
        st_next.armed = st_reg.ctrl.tick_enable;
        st_next.tick_irq = fall;
        st_next.tick_take = fall & tick_irq_enable & irq_master_flag;
        // pin idles high when off, else follows the inverted tap
        if (st_reg.ctrl.buzzer_out_enable) begin
            st_next.buzzer_n = ~buz_tap;
        end else begin
            st_next.buzzer_n = 1'b1;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg.ctrl <= CTRL_RESET;
            st_reg.waitreq <= 1'b1;
            st_reg.rdata <= 32'h0000_0000;
            st_reg.prev_tap <= 1'b0;
            st_reg.armed <= 1'b0;
            st_reg.tick_irq <= 1'b0;
            st_reg.tick_take <= 1'b0;
            st_reg.buzzer_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state flops
    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign tick_irq = st_reg.tick_irq;
    assign tick_irq_take = st_reg.tick_take;
    assign buzzer_out_pin_n = st_reg.buzzer_n;

    // ==========================================================
    // checks
    tick_on_fall_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (st_reg.ctrl.tick_enable && $past(st_reg.ctrl.tick_enable)
            && $past(tick_tap) && !tick_tap) |=> tick_irq)
        else $error("falling tap edge gave no tick request");

    tick_quiet_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !st_reg.ctrl.tick_enable |=> !tick_irq)
        else $error("tick request while disabled");

    tick_settled_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(st_reg.ctrl.tick_enable) |-> ##1 !tick_irq)
        else $error("tick request raised against a stale tap");

    tick_decode_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!clock_mode.slow_mode && !clock_mode.prescaler_source_select
            && st_reg.ctrl.tick_period_select == 3'h4)
            |-> tick_tap == fast_chain[12])
        else $error("period code 100 not on fast bit 12");

    slow_decode_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (clock_mode.slow_mode && st_reg.ctrl.tick_period_select == 3'h1)
            |-> tick_tap == slow_chain[12])
        else $error("slow mode code 001 not on slow bit 12");

    buzzer_decode_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (clock_mode.prescaler_source_select
            && st_reg.ctrl.buzzer_freq_select == 2'h3)
            |-> buz_tap == slow_chain[1])
        else $error("buzzer code 11 not on slow bit 1");

    buzzer_off_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !st_reg.ctrl.buzzer_out_enable |=> buzzer_out_pin_n)
        else $error("buzzer pin low while disabled");

    buzzer_wave_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        st_reg.ctrl.buzzer_out_enable |=> buzzer_out_pin_n == !$past(buz_tap))
        else $error("buzzer pin does not follow tap");

    ctrl_write_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (avs_write && !avs_waitrequest && avs_address == CTRL_ADDR
            && avs_byteenable[0])
            |=> st_reg.ctrl == ($past(avs_writedata[7:0]) & CTRL_WRITE_MASK))
        else $error("control write not stored");

    irq_gate_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        tick_irq_take |-> tick_irq && $past(irq_master_flag)
            && $past(tick_irq_enable))
        else $error("tick taken without both enables");

    bus_answer_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest low not exactly one cycle");

    take_follows_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (tick_irq && $past(irq_master_flag) && $past(tick_irq_enable))
            |-> tick_irq_take)
        else $error("enabled tick request not passed on");

    slow_column_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (clock_mode.prescaler_source_select
            && st_reg.ctrl.tick_period_select == 3'h7)
            |-> tick_tap == slow_chain[0])
        else $error("period code 111 not on slow bit 0");

    buzzer_fast_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!clock_mode.slow_mode && !clock_mode.prescaler_source_select
            && st_reg.ctrl.buzzer_freq_select == 2'h2)
            |-> buz_tap == fast_chain[10])
        else $error("buzzer code 10 not on fast bit 10");

    read_upper_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

endmodule : periodic_tick_unit

// >>> sim/piezo_buzzer_model.sv
// piezo buzzer stand-in: measures high and low run lengths of the pin
// assumes the pin is sampled on the clock that drives it
`timescale 1ns/1ps
module piezo_buzzer_model (
    // clock and pin
    input wire logic ref_clk,
    input wire logic buzzer_out_pin_n,
    // last finished run lengths, in cycles
    output int high_len,
    output int low_len
);
    // ==========================================================
    // run counter; the first run after enable is partial, so wait 2 periods
    int run = 0;
    logic last = 1'b1;
    always @(posedge ref_clk) begin
        if (buzzer_out_pin_n !== last) begin
            if (last === 1'b1) high_len <= run;
            else low_len <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        last <= buzzer_out_pin_n;
    end
endmodule : piezo_buzzer_model

// >>> sim/periodic_tick_unit_test.sv
// testbench for the periodic tick unit, avalon tasks and tap timing
// assumes a free-running counter stands in for the shared divider chain
`timescale 1ns/1ps
module periodic_tick_unit_test
    import tick_pkg::*;
;
    // ==========================================================
    // stimulus and observation
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] avs_address = 2'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, tick_irq, tick_irq_take, buzzer_out_pin_n;
    logic [23:0] cnt = 24'h0;
    clock_mode_t clock_mode = '0;
    logic tick_irq_enable = 1'b1;
    logic irq_master_flag = 1'b1;
    int high_len, low_len, n, m;
    int miscompares = 0, compares = 0, takes = 0, irqs = 0;
    // exponents of the tap dividers per code
    localparam int FE [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    localparam int SE [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
    localparam int BF [4] = '{13, 12, 11, 10};
    localparam int BS [4] = '{5, 4, 3, 2};

    always #2 ref_clk = ~ref_clk;

    // chain counter: fast_clock is ref_clk, slow_clock is half of it
    always @(posedge ref_clk) begin
        cnt <= cnt + 24'h1;
        if (tick_irq === 1'b1) irqs <= irqs + 1;
        if (tick_irq_take === 1'b1) takes <= takes + 1;
    end

    periodic_tick_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fast_chain(cnt[22:0]),
        .slow_chain(cnt[15:1]), .clock_mode(clock_mode),
        .tick_irq_enable(tick_irq_enable),
        .irq_master_flag(irq_master_flag), .tick_irq(tick_irq),
        .tick_irq_take(tick_irq_take), .buzzer_out_pin_n(buzzer_out_pin_n));

    piezo_buzzer_model i_buzzer (.ref_clk(ref_clk),
        .buzzer_out_pin_n(buzzer_out_pin_n), .high_len(high_len),
        .low_len(low_len));

    // ==========================================================
    // reporting
    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", s, e, g);
        end
    endtask : chk

    // ==========================================================
    // avalon cycle: hold until waitrequest is sampled low, then release
    task bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 64);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            stop_test();
        end
        @(posedge ref_clk);
    endtask : bus

    task wt(input logic [7:0] v);
        bus(1'b1, CTRL_ADDR, {24'h0, v});
    endtask : wt

    task rd(input string s, input logic [1:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask : rd

    // bounded wait for the next tick pulse, count of cycles in k
    task wait_irq(input int lim, output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (tick_irq !== 1'b1 && k <= lim);
        if (k > lim) begin
            miscompares++;
            stop_test();
        end
    endtask : wait_irq

    // code and enable in one write, then disable with the code kept
    task tick_case(input bit sl, input bit pr, input logic [2:0] c);
        int p, k;
        p = sl | pr ? 2 << SE[c] : 1 << FE[c];
        clock_mode <= '{slow_mode: sl, prescaler_source_select: pr};
        wt({4'h0, 1'b1, c});
        wait_irq(p + 4, k);
        wait_irq(p + 4, k);
        chk("tick gap", p, k);
        wt({4'h0, 1'b0, c});
    endtask : tick_case

    task buz_case(input bit pr, input logic [1:0] c);
        int p;
        p = pr ? 2 << BS[c] : 1 << BF[c];
        clock_mode <= '{slow_mode: 1'b0, prescaler_source_select: pr};
        wt({1'b1, c, 5'h00});
        repeat (2 * p + 8) @(posedge ref_clk);
        chk("buzzer high", p / 2, high_len);
        chk("buzzer low", p / 2, low_len);
        wt({1'b0, c, 5'h00});
        repeat (4) @(posedge ref_clk);
        chk("buzzer off", 32'h1, {31'h0, buzzer_out_pin_n});
    endtask : buz_case

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd("ctrl reset", CTRL_ADDR, 32'h0);
        chk("pin idle", 32'h1, {31'h0, buzzer_out_pin_n});
        wt(8'hFF);
        rd("ctrl rw", CTRL_ADDR, 32'hEF);
        bus(1'b1, 2'h2, 32'h0);
        bus(1'b1, STATUS_ADDR, 32'h0);
        rd("unmapped", 2'h2, 32'h0);
        avs_byteenable <= 4'h0;
        wt(8'h00);
        avs_byteenable <= 4'hF;
        rd("no lane", CTRL_ADDR, 32'hEF);
        wt(8'h67);
        // status shows the mode inputs; the tap bits run free, so masked
        clock_mode <= '{slow_mode: 1'b0, prescaler_source_select: 1'b1};
        bus(1'b0, STATUS_ADDR, 32'h0);
        chk("status", 32'h4, q & 32'hFFFF_FFFC);
        n = irqs;
        repeat (600) @(posedge ref_clk);
        chk("tick off", n, irqs);
        chk("pin off", 32'h1, {31'h0, buzzer_out_pin_n});
        for (int c = 4; c < 8; c++) tick_case(1'b0, 1'b0, c[2:0]);
        chk("takes", irqs, takes);
        m = takes;
        irq_master_flag <= 1'b0;
        for (int c = 2; c < 8; c++) tick_case(1'b0, 1'b1, c[2:0]);
        irq_master_flag <= 1'b1;
        tick_irq_enable <= 1'b0;
        tick_case(1'b1, 1'b1, 3'h1);
        chk("masked", m, takes);
        for (int i = 0; i < 6; i++) begin
            buz_case(i > 1, 2'(i < 2 ? i + 2 : i - 2));
        end
        stop_test();
    end
endmodule : periodic_tick_unit_test
